// ---- rtl/frt_icu_defines.vh ----
// register offsets, field positions, reset values and interrupt numbers for the free-run capture timer
// assumes: included by the design files of this block only
`ifndef FRT_ICU_DEFINES_VH
`define FRT_ICU_DEFINES_VH

// ==================================================
// register byte offsets
`define OFF_COUNT_CONTROL_STATUS 8'h00
`define OFF_FREE_COUNT_VALUE     8'h04
`define OFF_EDGE_SELECT          8'h08
`define OFF_IRQ_STATUS           8'h0C
`define OFF_IRQ_ENABLE           8'h10
`define OFF_IRQ_CLEAR            8'h14
`define OFF_AUTO_XFER_SELECT     8'h18
`define OFF_CAPTURE0             8'h20
`define OFF_CAPTURE1             8'h24
`define OFF_CAPTURE2             8'h28
`define OFF_CAPTURE3             8'h2C
`define OFF_IRQ_NUMBERS          8'h30

// ==================================================
// count_control_status fields
`define CCS_DIV_LSB   0
`define CCS_DIV_MSB   1
`define CCS_STOP_BIT  4
`define CCS_CLEAR_BIT 5

// ==================================================
// status bit positions: overflow then captures 0..3
`define ST_OVF  0
`define ST_CAP0 1

// ==================================================
// edge select codes, two bits per channel
`define EDGE_NONE    2'b00
`define EDGE_RISE    2'b01
`define EDGE_FALL    2'b10
`define EDGE_BOTH    2'b11

// ==================================================
// reset values and interrupt request numbers
`define COUNT_RESET   16'h0000
`define CCS_RESET     8'h00
`define IRQ_NUM_OVF   8'h13
`define IRQ_NUM_CAP23 8'h1E
`define IRQ_NUM_CAP0  8'h17
`define IRQ_NUM_CAP1  8'h19

// ==================================================
// prescaler ratios as shift counts: 1/2, 1/4, 1/8, 1/16 of the machine clock
`define DIV_SHIFT0 4'd1
`define DIV_SHIFT1 4'd2
`define DIV_SHIFT2 4'd3
`define DIV_SHIFT3 4'd4

`endif

// ---- rtl/capture_channel.v ----
// one input-capture channel: synchroniser, edge detector and capture data latch
// assumes: capture pin synchronous-ish to core_clk; time base supplied by the counter
`timescale 1ns/1ns
`include "frt_icu_defines.vh"

module capture_channel #(
	parameter WIDTH = 16
) (
	input  wire             core_clk,
	input  wire             rst_n,
	input  wire             pin,
	input  wire [1:0]       edge_sel,
	input  wire [WIDTH-1:0] time_base,
	output reg  [WIDTH-1:0] captured,
	output wire             event_pulse
);

	reg sync_a;
	reg sync_b;
	reg last;

	// ==================================================
	// two flops then an edge history flop; only sync_b is looked at
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			last   <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			last   <= sync_b;
		end
	end

	wire rise = sync_b & ~last;
	wire fall = ~sync_b & last;

	assign event_pulse = (edge_sel[0] & rise) | (edge_sel[1] & fall);

	// ==================================================
	// latch the shared time base on the detected edge
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			captured <= {WIDTH{1'b0}};
		else if (event_pulse)
			captured <= time_base;
	end

endmodule // capture_channel

// ---- rtl/freerun_input_capture_timer.v ----
// free-running 16-bit counter with prescaler and four input-capture channels, axi4-lite slave
// assumes: one clock core_clk at 100 MHz, async active-low reset, capture pins sampled on core_clk
//
// How it works
// - a 16-bit up counter advances once per prescaled count tick
// - prescaler picks one of four divide ratios from the control/status register
// - counter overflow raises an interrupt request when software enables it
// - overflow request can instead trigger the automatic transfer service
// - counter goes to 0000 on reset or on the software clear bit
// - the live count is fed to every capture channel as time base
// - a selected edge copies the count into that channel's capture register
// - each channel selects rising, falling or both edges
// - a capture edge raises that channel's interrupt when enabled
// - a capture request can instead start the automatic transfer service
// - four capture pins, each with its own channel and capture register
// - reading the count register returns the current 16-bit count
// - writing the count register while halted loads the counter
// - overflow interrupt uses request number 19 (13h)
// - capture channels 2 and 3 share request number 30
`timescale 1ns/1ns
`include "frt_icu_defines.vh"

module freerun_input_capture_timer #(
	parameter WIDTH    = 16,
	parameter CHANNELS = 4
) (
	input  wire                core_clk,
	input  wire                rst_n,
	input  wire [7:0]          s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output wire                s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output wire                s_axi_wready,
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	input  wire [7:0]          s_axi_araddr,
	input  wire                s_axi_arvalid,
	output wire                s_axi_arready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	input  wire [CHANNELS-1:0] capture_pin,
	output wire                irq,
	output wire                irq_overflow,
	output wire                irq_capture0,
	output wire                irq_capture1,
	output wire                irq_capture23,
	output wire [7:0]          irq_overflow_number,
	output wire [7:0]          irq_capture23_number,
	output wire                auto_xfer_overflow,
	output wire                auto_xfer_capture0,
	output wire                auto_xfer_capture1,
	output wire                auto_xfer_capture23
);

	// ==================================================
	// state
	reg  [7:0]          count_control_status;
	reg  [WIDTH-1:0]    free_count_value;
	reg  [7:0]          edge_select;
	reg  [4:0]          irq_status;
	reg  [4:0]          irq_enable;
	reg  [4:0]          auto_xfer_select;
	reg  [15:0]         prescale;
	reg  [7:0]          aw_addr;
	reg                 aw_held;
	reg  [31:0]         w_data;
	reg  [3:0]          w_strb;
	reg                 w_held;
	wire [CHANNELS-1:0] cap_event;
	wire [WIDTH-1:0]    cap_value [0:CHANNELS-1];

	// ==================================================
	// byte lane merge, used by the control, count and edge select registers
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// ==================================================
	// axi write: address and data accepted in either order, then one response
	// ready falls while a response waits, so a second write cannot overtake it
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

	wire [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
	wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
	wire        aw_ok    = aw_held | (s_axi_awvalid & s_axi_awready);
	wire        w_ok     = w_held | (s_axi_wvalid & s_axi_wready);
	wire        wr_fire  = aw_ok & w_ok & ~s_axi_bvalid;

	wire        wr_known = (wr_addr == `OFF_COUNT_CONTROL_STATUS) | (wr_addr == `OFF_FREE_COUNT_VALUE) |
	                       (wr_addr == `OFF_EDGE_SELECT) | (wr_addr == `OFF_IRQ_ENABLE) |
	                       (wr_addr == `OFF_IRQ_CLEAR) | (wr_addr == `OFF_AUTO_XFER_SELECT);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held      <= 1'b0;
			aw_addr      <= 8'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
			end else begin
				if (s_axi_awvalid & s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (s_axi_wvalid & s_axi_wready) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (s_axi_bvalid & s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	wire wr_ccs   = wr_fire & (wr_addr == `OFF_COUNT_CONTROL_STATUS);
	wire wr_count = wr_fire & (wr_addr == `OFF_FREE_COUNT_VALUE);
	wire wr_clear = wr_fire & (wr_addr == `OFF_IRQ_CLEAR);
	wire [31:0] ccs_new = merge({24'h00_0000, count_control_status}, wr_data, wr_strb);

	// ==================================================
	// merged write words, cut to register width below
	wire [31:0] edge_new  = merge({24'h00_0000, edge_select}, wr_data, wr_strb);
	wire [31:0] count_new = merge({16'h0000, free_count_value}, wr_data, wr_strb);

	// ==================================================
	// control registers; the clear bit is a pulse and never stored
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_control_status <= `CCS_RESET;
			edge_select          <= 8'h00;
			irq_enable           <= 5'h00;
			auto_xfer_select     <= 5'h00;
		end else if (wr_fire) begin
			if (wr_ccs) begin
				count_control_status <= ccs_new[7:0];
				count_control_status[`CCS_CLEAR_BIT] <= 1'b0;
			end
			if (wr_addr == `OFF_EDGE_SELECT)
				edge_select <= edge_new[7:0];
			if (wr_addr == `OFF_IRQ_ENABLE)
				irq_enable <= wr_strb[0] ? wr_data[4:0] : irq_enable;
			if (wr_addr == `OFF_AUTO_XFER_SELECT)
				auto_xfer_select <= wr_strb[0] ? wr_data[4:0] : auto_xfer_select;
		end
	end

	// ==================================================
	// prescaler: tick once every 2^n machine clocks
	// mask compare, not a reload counter: the ratio may change without a stall
	reg  [3:0] div_shift;
	always @* begin
		case (count_control_status[`CCS_DIV_MSB:`CCS_DIV_LSB])
			2'd0:    div_shift = `DIV_SHIFT0;
			2'd1:    div_shift = `DIV_SHIFT1;
			2'd2:    div_shift = `DIV_SHIFT2;
			2'd3:    div_shift = `DIV_SHIFT3;
			default: div_shift = `DIV_SHIFT0;
		endcase
	end

	wire [15:0] div_mask = (16'h0001 << div_shift) - 16'h0001;
	wire        halted   = count_control_status[`CCS_STOP_BIT];
	wire        tick     = ~halted & ((prescale & div_mask) == div_mask);
	wire        sw_clear = wr_ccs & ccs_new[`CCS_CLEAR_BIT];
	wire        wrap     = tick & (free_count_value == {WIDTH{1'b1}});

	// ==================================================
	// free-running counter
	// clear beats preset and tick so software always sees 0000 after it
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale         <= 16'h0000;
			free_count_value <= `COUNT_RESET;
		end else begin
			prescale <= halted ? 16'h0000 : prescale + 16'h0001;
			if (sw_clear) begin
				free_count_value <= `COUNT_RESET;
				prescale         <= 16'h0000;
			end else if (wr_count & halted) begin
				// a preset while running is ignored: loading mid-count would skew captures
				free_count_value <= count_new[WIDTH-1:0];
			end else if (tick) begin
				free_count_value <= free_count_value + 1'b1;
			end
		end
	end

	// ==================================================
	// capture channels, one pin each, all share the live count
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : cap
			capture_channel #(
				.WIDTH(WIDTH)
			) u_chan (
				.core_clk    (core_clk),
				.rst_n       (rst_n),
				.pin         (capture_pin[g]),
				.edge_sel    (edge_select[2*g +: 2]),
				.time_base   (free_count_value),
				.captured    (cap_value[g]),
				.event_pulse (cap_event[g])
			);
		end
	endgenerate

	// ==================================================
	// sticky status; a new event wins over a clear in the same cycle
	// clear uses byte lane 0 only, like enable and select
	wire [4:0] events  = {cap_event[3:0], wrap};
	wire [4:0] clr_bits = (wr_clear & wr_strb[0]) ? wr_data[4:0] : 5'h00;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			irq_status <= 5'h00;
		else
			irq_status <= (irq_status & ~clr_bits) | events;
	end

	wire [4:0] pend = irq_status & irq_enable;
	wire [4:0] to_cpu = pend & ~auto_xfer_select;
	wire [4:0] to_xfer = pend & auto_xfer_select;

	assign irq                  = |pend;
	assign irq_overflow         = to_cpu[`ST_OVF];
	assign irq_capture0         = to_cpu[`ST_CAP0];
	assign irq_capture1         = to_cpu[`ST_CAP0+1];
	assign irq_capture23        = to_cpu[`ST_CAP0+2] | to_cpu[`ST_CAP0+3];
	assign irq_overflow_number  = `IRQ_NUM_OVF;
	assign irq_capture23_number = `IRQ_NUM_CAP23;
	assign auto_xfer_overflow   = to_xfer[`ST_OVF];
	assign auto_xfer_capture0   = to_xfer[`ST_CAP0];
	assign auto_xfer_capture1   = to_xfer[`ST_CAP0+1];
	assign auto_xfer_capture23  = to_xfer[`ST_CAP0+2] | to_xfer[`ST_CAP0+3];

	// ==================================================
	// axi read: one-cycle registered answer
	// unmapped reads answer slverr with zero data
	assign s_axi_arready = ~s_axi_rvalid;

	reg [31:0] rd_word;
	reg        rd_ok;
	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`OFF_COUNT_CONTROL_STATUS: rd_word = {24'h00_0000, count_control_status};
			`OFF_FREE_COUNT_VALUE:     rd_word = {16'h0000, free_count_value};
			`OFF_EDGE_SELECT:          rd_word = {24'h00_0000, edge_select};
			`OFF_IRQ_STATUS:           rd_word = {27'h000_0000, irq_status};
			`OFF_IRQ_ENABLE:           rd_word = {27'h000_0000, irq_enable};
			`OFF_IRQ_CLEAR:            rd_word = 32'h0000_0000;
			`OFF_AUTO_XFER_SELECT:     rd_word = {27'h000_0000, auto_xfer_select};
			`OFF_CAPTURE0:             rd_word = {16'h0000, cap_value[0]};
			`OFF_CAPTURE1:             rd_word = {16'h0000, cap_value[1]};
			`OFF_CAPTURE2:             rd_word = {16'h0000, cap_value[2]};
			`OFF_CAPTURE3:             rd_word = {16'h0000, cap_value[3]};
			`OFF_IRQ_NUMBERS:          rd_word = {16'h0000, `IRQ_NUM_CAP23, `IRQ_NUM_OVF};
			default: begin
				rd_word = 32'h0000_0000;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // freerun_input_capture_timer

// ---- verif/pin_source.sv ----
// partner model: external sources driving the four capture pins
// assumes: bench calls drive() from its own thread, pins idle low
`timescale 1ns/1ns
module pin_source (
	input  wire       core_clk,
	output reg  [3:0] pins
);
	initial pins = 4'h0;
	// ==========
	// change just after an edge, never on it
	task drive(input [3:0] m);
		begin
			@(posedge core_clk);
			pins <= m;
		end
	endtask
endmodule // pin_source

// ---- verif/frt_checker_properties.sv ----
// checker: bus timing, interrupt routing and constant request numbers
// assumes: bound to the top module, single clock domain
`timescale 1ns/1ns
module frt_checker #(
	parameter CHANNELS = 4
) (
	input wire                core_clk,
	input wire                rst_n,
	input wire                s_axi_awvalid,
	input wire                s_axi_awready,
	input wire                s_axi_wvalid,
	input wire                s_axi_wready,
	input wire                s_axi_bvalid,
	input wire                s_axi_arvalid,
	input wire                s_axi_arready,
	input wire                s_axi_rvalid,
	input wire                irq,
	input wire                irq_overflow,
	input wire                irq_capture0,
	input wire                irq_capture1,
	input wire                irq_capture23,
	input wire [7:0]          irq_overflow_number,
	input wire [7:0]          irq_capture23_number,
	input wire                auto_xfer_overflow,
	input wire                auto_xfer_capture0,
	input wire                auto_xfer_capture1,
	input wire                auto_xfer_capture23
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// bus steps
	sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
		else $error("write answer late");
	// ==========
	// interrupt outputs
	a_ovf_number: assert property (irq_overflow_number == 8'h13)
		else $error("overflow request number wrong");
	a_cap_number: assert property (irq_capture23_number == 8'h1E)
		else $error("shared capture request number wrong");
	a_ovf_route: assert property (!(irq_overflow && auto_xfer_overflow))
		else $error("overflow routed both ways");
	a_cap_route: assert property (!(irq_capture0 && auto_xfer_capture0))
		else $error("capture routed both ways");
	a_irq_summary: assert property (irq == (irq_overflow || irq_capture0 || irq_capture1 || irq_capture23 ||
		auto_xfer_overflow || auto_xfer_capture0 || auto_xfer_capture1 || auto_xfer_capture23))
		else $error("summary interrupt disagrees");
endmodule // frt_checker
bind freerun_input_capture_timer frt_checker #(.CHANNELS(CHANNELS)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .irq(irq),
	.irq_overflow(irq_overflow), .irq_capture0(irq_capture0), .irq_capture1(irq_capture1),
	.irq_capture23(irq_capture23), .irq_overflow_number(irq_overflow_number),
	.irq_capture23_number(irq_capture23_number), .auto_xfer_overflow(auto_xfer_overflow),
	.auto_xfer_capture0(auto_xfer_capture0), .auto_xfer_capture1(auto_xfer_capture1),
	.auto_xfer_capture23(auto_xfer_capture23));

// ---- verif/freerun_input_capture_timer_bench.sv ----
// bench: axi4-lite master, counter, prescaler, overflow and capture scenarios
// assumes: pin_source partner, 100 MHz core_clk
`timescale 1ns/1ns
module freerun_input_capture_timer_bench;
	reg         core_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg  [7:0]  awaddr = 0, araddr = 0;
	reg  [31:0] wdata = 0, v, e;
	reg  [1:0]  r;
	reg         ad, dd, bd;
	wire        awready, wready, bvalid, arready, rvalid, irq, i_ov, i_c0, i_c1, i_c23, a_ov, a_c0, a_c1, a_c23;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [7:0]  n_ov, n_c23;
	wire [3:0]  pins;
	integer     n_mismatch = 0, checks = 0, k, i, c;
	always #5 core_clk = ~core_clk;
	pin_source src (.core_clk(core_clk), .pins(pins));
	freerun_input_capture_timer DUT (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.capture_pin(pins), .irq(irq), .irq_overflow(i_ov), .irq_capture0(i_c0), .irq_capture1(i_c1),
		.irq_capture23(i_c23), .irq_overflow_number(n_ov), .irq_capture23_number(n_c23),
		.auto_xfer_overflow(a_ov), .auto_xfer_capture0(a_c0), .auto_xfer_capture1(a_c1),
		.auto_xfer_capture23(a_c23));
	// ==========
	// shared tasks
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	// aw and w offered together, each released when taken
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
			ad = 0; dd = 0; bd = 0;
			for (k = 0; k < 50 && !bd; k = k + 1) begin
				@(posedge core_clk);
				if (ad && dd && bvalid) begin bd = 1; r = bresp; end
				if (!ad && awready) begin ad = 1; awvalid <= 0; end
				if (!dd && wready) begin dd = 1; wvalid <= 0; end
			end
			bready <= 0;
			if (!bd) begin n_mismatch = n_mismatch + 1; summarize; end
		end
	endtask
	task rd(input [7:0] a, output [31:0] d);
		begin
			@(posedge core_clk);
			araddr <= a; arvalid <= 1; rready <= 1;
			ad = 0; bd = 0;
			for (k = 0; k < 50 && !bd; k = k + 1) begin
				@(posedge core_clk);
				if (ad && rvalid) begin bd = 1; d = rdata; r = rresp; end
				if (!ad && arready) begin ad = 1; arvalid <= 0; end
			end
			rready <= 0;
			if (!bd) begin n_mismatch = n_mismatch + 1; summarize; end
		end
	endtask
	// ==========
	// scenarios
	task t_reset;
		begin
			rd(8'h04, v); chk(v, 32'h0000_0000);
			rd(8'h30, v); chk(v, 32'h0000_1E13);
			chk({n_c23, n_ov}, 32'h0000_1E13);
			rd(8'h3C, v); chk({30'h0, r}, 32'h0000_0002);
			chk(v, 32'h0000_0000);
			wr(8'h0C, 32'h0000_0001); chk({30'h0, r}, 32'h0000_0002);
			wr(8'h10, 32'h0000_0000); chk({30'h0, r}, 32'h0000_0000);
			$display("test reset done");
		end
	endtask
	// window of ~67 running cycles, so allow for write latency
	task t_count;
		begin
			for (c = 0; c < 4; c = c + 1) begin
				wr(8'h00, 32'h0000_0030); wr(8'h00, c); cyc(64); wr(8'h00, 32'h0000_0010);
				rd(8'h04, v); chk(v >= (64 >> (c + 1)) && v <= (64 >> (c + 1)) + 3, 1);
			end
			wr(8'h04, 32'h0000_FFFE); rd(8'h04, v); chk(v, 32'h0000_FFFE);
			wr(8'h10, 32'h0000_0001); wr(8'h14, 32'h0000_001F); wr(8'h00, 32'h0000_0000); cyc(10);
			rd(8'h0C, v); chk(v[0], 1);
			chk({irq, i_ov, a_ov}, 3'b110);
			wr(8'h18, 32'h0000_0001); chk({irq, i_ov, a_ov}, 3'b101);
			wr(8'h18, 32'h0000_0000); cyc(5); chk(i_ov, 1);
			wr(8'h14, 32'h0000_0001); chk(irq, 0);
			wr(8'h04, 32'h0000_8000); rd(8'h04, v); chk(v < 32'h0000_0100, 1);
			wr(8'h00, 32'h0000_0030); rd(8'h04, v); chk(v, 32'h0000_0000);
			$display("test count done");
		end
	endtask
	// count halted: rise sees one preset, fall sees another
	task t_capture;
		begin
			wr(8'h10, 32'h0000_001E);
			for (i = 0; i < 4; i = i + 1) for (c = 3; c >= 0; c = c - 1) begin
				wr(8'h04, 32'h1111 * (c + 1) + i); wr(8'h08, c << (2 * i)); wr(8'h14, 32'h0000_001E);
				src.drive(4'h1 << i); cyc(5);
				wr(8'h04, 32'hA000 + i); src.drive(4'h0); cyc(5);
				if (c == 1) e = 32'h1111 * 2 + i;
				else if (c != 0) e = 32'hA000 + i;
				rd(8'h0C, v); chk(v[1 + i], c != 0);
				rd(8'h20 + 4 * i, v); chk(v, e);
				chk(i == 0 ? i_c0 : i == 1 ? i_c1 : i_c23, c != 0);
			end
			wr(8'h08, 32'h0000_00FF); wr(8'h14, 32'h0000_001F); src.drive(4'hF); cyc(5);
			for (i = 0; i < 4; i = i + 1) begin
				rd(8'h20 + 4 * i, v); chk(v, 32'h0000_A003);
			end
			wr(8'h18, 32'h0000_001E); chk({a_c0, a_c1, a_c23, i_c0, i_c1, i_c23}, 6'b111000);
			wr(8'h18, 32'h0000_0000); wr(8'h14, 32'h0000_001F); chk(irq, 0);
			$display("test capture done");
		end
	endtask
	initial begin
		cyc(5);
		rst_n <= 1;
		t_reset;
		t_count;
		t_capture;
		summarize;
	end
endmodule // freerun_input_capture_timer_bench
